// [inc/dss_pkg.sv]
`default_nettype none
package dss_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned DSS_CLK_PERIOD_NS = 25;
  localparam int unsigned DSS_MS_NS = 1000000;
  // one millisecond in clock cycles
  localparam int unsigned DSS_MS_CYC = DSS_MS_NS / DSS_CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // start/stop scheme codes
  // ----------------------------------------------------------------
  localparam logic [3:0] DSS_SCH_FWD_REV = 4'h0;
  localparam logic [3:0] DSS_SCH_START_DIR = 4'h1;
  localparam logic [3:0] DSS_SCH_START_DIR_ALT = 4'h2;
  localparam logic [3:0] DSS_SCH_THREE_WIRE_PULSE = 4'h3;
  localparam logic [3:0] DSS_SCH_RUN_WITH_POT_RAISE = 4'h4;
  localparam logic [3:0] DSS_SCH_EDGE_FWD_REV = 4'h5;
  localparam logic [3:0] DSS_SCH_EDGE_RUN_DIRECTION = 4'h6;
  localparam logic [3:0] DSS_SCH_EDGE_RUN_WITH_ENABLE = 4'h7;
  localparam logic [3:0] DSS_SCH_EDGE_RUN_EDGE_HALT = 4'h8;

  // ----------------------------------------------------------------
  // control places, fault codes, reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] DSS_PLC_TERM = 2'h0;
  localparam logic [1:0] DSS_PLC_KPD = 2'h1;
  localparam logic [1:0] DSS_PLC_FB = 2'h2;
  localparam logic [7:0] DSS_FLT_NONE = 8'h00;
  localparam logic [7:0] DSS_FLT_EXT = 8'h33;
  localparam logic [15:0] DSS_REF_RST = 16'h0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // contact inputs, high = contact closed
  typedef struct packed {
    logic first_contact_input;
    logic second_contact_input;
    logic run_en;
    logic rev_sel;
    logic [2:0] preset;
    logic pot_up;
    logic pot_down;
    logic flt_rst;
    logic ext_flt_close;
    logic ext_flt_ok;
    logic ramp_sel;
    logic ramp_hold;
    logic dc_brake_input;
    logic jog;
    logic frc_term;
    logic frc_kpd;
    logic frc_fb;
  } dss_contacts_t;

  // sampler reset levels: the opening-type fault contact idles closed
  localparam dss_contacts_t DSS_CONT_IDLE = '{ext_flt_ok: 1'b1,
                                               default: '0};

  // command set of a keypad or fieldbus place
  typedef struct packed {
    logic run;
    logic rev;
    logic [15:0] ref_val;
  } dss_place_cmd_t;

  // decoded command bundle towards the drive
  typedef struct packed {
    logic run;
    logic rev;
    logic coast;
    logic warn_run_dis;
    logic [2:0] preset;
    logic pot_up;
    logic pot_down;
    logic flt;
    logic flt_clr;
    logic [7:0] flt_code;
    logic ramp_set2;
    logic hold_acc;
    logic hold_dec;
    logic dc_brake;
    logic jog;
    logic [1:0] place;
    logic settings_bank_select;
  } dss_cmd_t;

  // state of the command core
  typedef struct packed {
    dss_contacts_t sync1;
    dss_contacts_t sync2;
    dss_contacts_t prev;
    logic arm1;
    logic arm2;
    logic trun;
    logic trev;
    logic flt;
    logic [1:0] place;
    logic [15:0] pot;
    logic [31:0] potdiv;
    logic [15:0] ref_sel;
    dss_cmd_t cmd;
  } dss_core_st_t;

  // state of the reference interpolator
  typedef struct packed {
    logic [15:0] tgt;
    logic [15:0] cur;
    logic up;
    logic [15:0] mag;
    logic [31:0] n;
    logic [31:0] cnt;
    logic [32:0] err;
  } dss_interp_st_t;

endpackage : dss_pkg
`default_nettype wire

// [rtl/dss_interp.sv]
`timescale 1ns/100ps
`default_nettype none
module dss_interp
  import dss_pkg::*;
#(
  parameter int unsigned MS_CYC = DSS_MS_CYC
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // interval and target
  input wire logic [15:0] interval_ms_i,
  input wire logic [15:0] tgt_i,
  // interpolated reference
  output logic [15:0] ref_o
);

  dss_interp_st_t s_q;
  dss_interp_st_t s_d;
  logic [32:0] e;
  logic [31:0] n;

  // ----------------------------------------------------------------
  // line drawing between two targets
  // ----------------------------------------------------------------
  // error accumulation moves one lsb at a time, so the slope is
  // exact with no divider; it limits the slope to 1 lsb per cycle
  always_comb
  begin
    s_d = s_q;
    e = 33'h0;
    n = 32'(32'(interval_ms_i) * MS_CYC);
    // RULE22 ramp new target
    if (tgt_i != s_q.tgt)
    begin
      s_d.tgt = tgt_i;
      s_d.up = (tgt_i > s_q.cur);
      s_d.mag = (tgt_i > s_q.cur) ? 16'(tgt_i - s_q.cur)
                                  : 16'(s_q.cur - tgt_i);
      s_d.n = n;
      s_d.cnt = n;
      s_d.err = 33'h0;
      // zero interval means plain stepping
      if (n == 32'h0)
      begin
        s_d.cur = tgt_i;
      end
    end
    else if (s_q.cnt != 32'h0)
    begin
      s_d.cnt = s_q.cnt - 32'h1;
      e = s_q.err + 33'(s_q.mag);
      if (e >= 33'(s_q.n))
      begin
        e = e - 33'(s_q.n);
        s_d.cur = s_q.up ? 16'(s_q.cur + 16'h1)
                         : 16'(s_q.cur - 16'h1);
      end
      s_d.err = e;
      // land exactly on the target at the end
      if (s_q.cnt == 32'h1)
      begin
        s_d.cur = s_q.tgt;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign ref_o = s_q.cur;

endmodule : dss_interp
`default_nettype wire

// [rtl/dss_core.sv]
// Functional notes
// RULE1 - scheme 0: input one forward, two reverse
// RULE2 - scheme 0: both closed keeps first direction
// RULE3 - scheme 0: one opens, two closed reverses
// RULE4 - scheme 3: pulse start, stop on falling two
// RULE5 - edge schemes need contact seen open first
// RULE6 - scheme 4: run on one, two raises pot
// RULE7 - scheme 5: rising edges start forward/reverse
// RULE8 - scheme 6: edge start, open stops, two=reverse
// RULE9 - scheme 7: edge start, two open disables
// RULE10 - scheme 8: edge on one starts, two stops
// RULE11 - run enable removed: coast, block, warn
// RULE12 - reverse input only where two is unused
// RULE13 - three preset inputs form binary index
// RULE14 - pot down closed keeps lowering reference
// RULE15 - fault reset acts on rising edge only
// RULE16 - external fault inputs raise code 51
// RULE17 - ramp select open set1, closed set2
// RULE18 - ramp hold freezes, decel option allowed
// RULE19 - dc brake while stopped and input closed
// RULE20 - jog input selects jogging reference
// RULE21 - force inputs override place, setting untouched
// RULE22 - interpolate reference over set interval
// RULE23 - sample contacts, edge by previous sample
// RULE24 - force priority terminal, fieldbus, keypad
`timescale 1ns/100ps
`default_nettype none
module dss_core
  import dss_pkg::*;
#(
  parameter int unsigned MS_CYC = DSS_MS_CYC,
  parameter int unsigned POT_DIV = DSS_MS_CYC
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // contact inputs from the terminals
  input wire dss_contacts_t cont_i,
  // configuration
  input wire logic [3:0] scheme_i,
  input wire logic [1:0] cfg_place_i,
  input wire logic decel_ok_i,
  input wire logic pot_ref_sel_i,
  input wire logic [15:0] reference_interp_interval_i,
  // references and other places
  input wire logic [15:0] io_ref_i,
  input wire logic [15:0] jog_ref_i,
  input wire dss_place_cmd_t kpd_i,
  input wire dss_place_cmd_t fb_i,
  // decoded commands
  output dss_cmd_t cmd_o,
  output logic [15:0] ref_o,
  output logic [15:0] pot_ref_o
);

  dss_core_st_t s_q;
  dss_core_st_t s_d;
  dss_contacts_t c;
  dss_contacts_t p;
  dss_contacts_t rise;
  dss_contacts_t fall;
  logic [1:0] plc;
  logic plc_chg;
  logic ext_flt;
  logic clr;
  logic disarm;
  logic go1;
  logic go2;
  logic block;
  logic run;
  logic rev;
  logic pot_tick;
  logic pot_inc;
  logic pot_dec;
  logic [15:0] src_ref;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    // RULE23 two-stage sampling
    s_d.sync1 = cont_i;
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    c = s_q.sync2;
    p = s_q.prev;
    // RULE23 edges from previous sample
    rise = dss_contacts_t'(c & ~p);
    fall = dss_contacts_t'(~c & p);

    // RULE24 fixed force priority
    plc = c.frc_term ? DSS_PLC_TERM
        : c.frc_fb ? DSS_PLC_FB
        : c.frc_kpd ? DSS_PLC_KPD
        // RULE21 configured place returns
        : cfg_place_i;
    // the configured setting is an input, so it is never rewritten
    plc_chg = (plc != s_q.place);
    s_d.place = plc;

    // RULE16 closing or opening type
    ext_flt = c.ext_flt_close | ~c.ext_flt_ok;
    // RULE15 reset on rising edge
    clr = rise.flt_rst;
    // a fault still present wins over the reset edge
    s_d.flt = ext_flt | (s_q.flt & ~clr);

    // RULE11 blocked without run enable
    block = ~c.run_en | s_d.flt;

    // RULE5 disarm on reset, run enable drop, place change
    disarm = clr | plc_chg | ~c.run_en;
    // RULE5 arm only once contact is open
    s_d.arm1 = ~disarm & (s_q.arm1 | ~c.first_contact_input);
    s_d.arm2 = ~disarm & (s_q.arm2 | ~c.second_contact_input);
    go1 = rise.first_contact_input & s_q.arm1 & ~disarm;
    go2 = rise.second_contact_input & s_q.arm2 & ~disarm;

    // terminal start/stop schemes
    case (scheme_i)
      DSS_SCH_FWD_REV:
      begin
        // RULE1 level start forward/reverse
        if (c.first_contact_input & ~c.second_contact_input)
        begin
          s_d.trun = 1'b1;
          s_d.trev = 1'b0;
        end
        // RULE3 one opened, two held
        else if (~c.first_contact_input & c.second_contact_input)
        begin
          s_d.trun = 1'b1;
          s_d.trev = 1'b1;
        end
        // RULE2 both closed keep direction
        else if (c.first_contact_input)
        begin
          s_d.trun = 1'b1;
        end
        else
        begin
          s_d.trun = 1'b0;
        end
      end
      DSS_SCH_START_DIR, DSS_SCH_START_DIR_ALT:
      begin
        s_d.trun = c.first_contact_input;
        s_d.trev = c.second_contact_input;
      end
      DSS_SCH_THREE_WIRE_PULSE:
      begin
        // RULE4 start pulse, stop edge
        if (go1)
        begin
          s_d.trun = 1'b1;
        end
        if (fall.second_contact_input)
        begin
          s_d.trun = 1'b0;
        end
        // RULE12 separate reverse input
        s_d.trev = c.rev_sel;
      end
      DSS_SCH_RUN_WITH_POT_RAISE:
      begin
        // RULE6 level run on input one
        s_d.trun = c.first_contact_input;
        // RULE12 separate reverse input
        s_d.trev = c.rev_sel;
      end
      DSS_SCH_EDGE_FWD_REV:
      begin
        // the running direction's contact opening stops the drive
        if (s_q.trun & ~s_q.trev & ~c.first_contact_input)
        begin
          s_d.trun = 1'b0;
        end
        if (s_q.trun & s_q.trev & ~c.second_contact_input)
        begin
          s_d.trun = 1'b0;
        end
        // RULE7 rising edge per direction
        if (go1)
        begin
          s_d.trun = 1'b1;
          s_d.trev = 1'b0;
        end
        else if (go2)
        begin
          s_d.trun = 1'b1;
          s_d.trev = 1'b1;
        end
      end
      DSS_SCH_EDGE_RUN_DIRECTION:
      begin
        // RULE8 edge start, open stops
        if (go1)
        begin
          s_d.trun = 1'b1;
        end
        if (~c.first_contact_input)
        begin
          s_d.trun = 1'b0;
        end
        s_d.trev = c.second_contact_input;
      end
      DSS_SCH_EDGE_RUN_WITH_ENABLE:
      begin
        // RULE9 second input enables
        if (go1 & c.second_contact_input)
        begin
          s_d.trun = 1'b1;
        end
        if (~c.first_contact_input | ~c.second_contact_input)
        begin
          s_d.trun = 1'b0;
        end
        // RULE12 separate reverse input
        s_d.trev = c.rev_sel;
      end
      DSS_SCH_EDGE_RUN_EDGE_HALT:
      begin
        // RULE10 start edge, stop edge
        if (go1)
        begin
          s_d.trun = 1'b1;
        end
        // stop edge wins when both rise together
        if (rise.second_contact_input)
        begin
          s_d.trun = 1'b0;
        end
        // RULE12 separate reverse input
        s_d.trev = c.rev_sel;
      end
      default:
      begin
        s_d.trun = 1'b0;
      end
    endcase

    // RULE11 no start while disabled
    if (block | plc_chg | (plc != DSS_PLC_TERM))
    begin
      s_d.trun = 1'b0;
    end

    // RULE21 commands of active place
    case (plc)
      DSS_PLC_KPD:
      begin
        run = kpd_i.run;
        rev = kpd_i.rev;
        src_ref = kpd_i.ref_val;
      end
      DSS_PLC_FB:
      begin
        run = fb_i.run;
        rev = fb_i.rev;
        src_ref = fb_i.ref_val;
      end
      default:
      begin
        run = s_d.trun;
        rev = s_d.trev;
        src_ref = pot_ref_sel_i ? s_q.pot : io_ref_i;
      end
    endcase
    run = run & ~block;

    // motor potentiometer, moved only while running
    pot_tick = (s_q.potdiv == 32'(POT_DIV - 1));
    s_d.potdiv = pot_tick ? 32'h0 : 32'(s_q.potdiv + 32'h1);
    // RULE6 second input raises pot
    pot_inc = c.pot_up | ((scheme_i == DSS_SCH_RUN_WITH_POT_RAISE)
                          & c.second_contact_input);
    // RULE14 lower while closed
    pot_dec = c.pot_down;
    if (pot_tick & s_q.cmd.run & (pot_inc != pot_dec))
    begin
      if (pot_inc & (s_q.pot != 16'hffff))
      begin
        s_d.pot = 16'(s_q.pot + 16'h1);
      end
      else if (pot_dec & (s_q.pot != 16'h0000))
      begin
        s_d.pot = 16'(s_q.pot - 16'h1);
      end
    end

    // RULE20 jogging reference wins
    s_d.ref_sel = c.jog ? jog_ref_i : src_ref;

    // registered command bundle
    s_d.cmd.run = run;
    s_d.cmd.rev = rev;
    // RULE11 coast and warning
    s_d.cmd.coast = ~c.run_en;
    s_d.cmd.warn_run_dis = ~c.run_en;
    // RULE13 binary preset index
    s_d.cmd.preset = c.preset;
    s_d.cmd.pot_up = pot_inc;
    s_d.cmd.pot_down = pot_dec;
    s_d.cmd.flt = s_d.flt;
    // RULE15 one pulse per edge
    s_d.cmd.flt_clr = clr & ~ext_flt & s_q.flt;
    // RULE16 external fault code
    s_d.cmd.flt_code = s_d.flt ? DSS_FLT_EXT : DSS_FLT_NONE;
    // RULE17 ramp time set
    s_d.cmd.ramp_set2 = c.ramp_sel;
    // RULE18 ramp hold with option
    s_d.cmd.hold_acc = c.ramp_hold;
    s_d.cmd.hold_dec = c.ramp_hold & ~decel_ok_i;
    // RULE19 dc brake when stopped
    s_d.cmd.dc_brake = c.dc_brake_input & ~run;
    s_d.cmd.jog = c.jog;
    s_d.cmd.place = plc;
    // bank storage sits outside, so the select stays at zero
    s_d.cmd.settings_bank_select = 1'b0;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // reset disarms both edge starts; samplers start at idle levels so the
  // opening-type fault input cannot latch a false fault at release
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      s_q <= '{sync1: DSS_CONT_IDLE, sync2: DSS_CONT_IDLE,
               prev: DSS_CONT_IDLE, default: '0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign cmd_o = s_q.cmd;
  assign pot_ref_o = s_q.pot;

  // ----------------------------------------------------------------
  // reference interpolation
  // ----------------------------------------------------------------
  // RULE22 smooth slow updates
  dss_interp #(
    .MS_CYC(MS_CYC)
  ) u_interp (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .interval_ms_i(reference_interp_interval_i),
    .tgt_i(s_q.ref_sel),
    .ref_o(ref_o)
  );

endmodule : dss_core
`default_nettype wire

// [verif/dss_contact_model.sv]
`timescale 1ns/100ps
`default_nettype none
module dss_contact_model
  import dss_pkg::*;
(
  // clock
  input wire logic clk_i,
  // contact positions asked for by the bench
  input wire dss_contacts_t req_i,
  // contact levels at the terminals
  output var dss_contacts_t cont_o
);
  // contacts move just after an edge, never on the sampling instant
  initial cont_o = '0;
  always @(posedge clk_i)
  begin
    cont_o <= req_i;
  end
endmodule : dss_contact_model
`default_nettype wire

// [verif/dss_core_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module dss_core_sva
  import dss_pkg::*;
#(
  parameter int unsigned MS_CYC = DSS_MS_CYC,
  parameter int unsigned POT_DIV = DSS_MS_CYC
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // watched inputs
  input wire dss_contacts_t cont_i,
  input wire logic decel_ok_i,
  // watched outputs
  input wire dss_cmd_t cmd_o,
  input wire logic [15:0] pot_ref_o
);
  // one domain; a contact reaches cmd_o three edges after the pin
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_runen_coast: assert property (
    !cont_i.run_en |-> ##3 (cmd_o.coast && cmd_o.warn_run_dis && !cmd_o.run))
    else $error("no coast after run enable drop");
  a_ext_fault: assert property (
    (cont_i.ext_flt_close || !cont_i.ext_flt_ok)
      |-> ##3 (cmd_o.flt && cmd_o.flt_code == DSS_FLT_EXT))
    else $error("external fault not raised");
  a_code_match: assert property (
    cmd_o.flt_code == (cmd_o.flt ? DSS_FLT_EXT : DSS_FLT_NONE))
    else $error("fault code does not match fault flag");
  a_clear_on_edge: assert property (
    cmd_o.flt_clr |-> $past(cont_i.flt_rst, 3) && !$past(cont_i.flt_rst, 4)
      && !cmd_o.flt)
    else $error("fault cleared without reset edge");
  a_preset_index: assert property (
    1'b1 |-> ##3 (cmd_o.preset == $past(cont_i.preset, 3)))
    else $error("preset index wrong");
  a_ramp_jog: assert property (
    1'b1 |-> ##3 (cmd_o.ramp_set2 == $past(cont_i.ramp_sel, 3)
      && cmd_o.jog == $past(cont_i.jog, 3)))
    else $error("ramp set or jog select wrong");
  a_hold_freeze: assert property (
    cont_i.ramp_hold |-> ##3 (cmd_o.hold_acc
      && cmd_o.hold_dec != $past(decel_ok_i)))
    else $error("ramp hold not applied");
  a_brake_input: assert property (
    cmd_o.dc_brake |-> $past(cont_i.dc_brake_input, 3))
    else $error("dc brake without input");
  a_pot_step: assert property (
    !$stable(pot_ref_o) |-> (pot_ref_o == $past(pot_ref_o) + 16'h0001)
      || (pot_ref_o == $past(pot_ref_o) - 16'h0001))
    else $error("motor pot jumped");
  a_force_term: assert property (
    cont_i.frc_term |-> ##3 (cmd_o.place == DSS_PLC_TERM))
    else $error("terminal force lost");
  a_force_fb: assert property (
    (cont_i.frc_fb && !cont_i.frc_term) |-> ##3 (cmd_o.place == DSS_PLC_FB))
    else $error("fieldbus force lost");

  // main scenarios reached
  c_fault_clear: cover property (cmd_o.flt_clr);
  c_place_kpd: cover property (cmd_o.place == DSS_PLC_KPD);
  c_run_rev: cover property (cmd_o.run && cmd_o.rev);
endmodule : dss_core_sva

bind dss_core dss_core_sva #(.MS_CYC(MS_CYC), .POT_DIV(POT_DIV))
  dss_core_sva_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cont_i(cont_i),
  .decel_ok_i(decel_ok_i), .cmd_o(cmd_o), .pot_ref_o(pot_ref_o));
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import dss_pkg::*;
();
  // short counts keep the run brief
  localparam int MS = 10;
  localparam int PD = 4;
  typedef struct packed {
    logic [3:0] sch;
    logic c1;
    logic c2;
    logic rs;
    logic run;
    logic rev;
  } dss_row_t;
  // scheme, contact one, two, reverse input -> run, direction
  localparam dss_row_t ROWS [29] = '{
    {4'h0, 5'b10110}, {4'h0, 5'b11010}, {4'h0, 5'b01011}, {4'h0, 5'b00000},
    {4'h0, 5'b01011}, {4'h0, 5'b11011}, {4'h0, 5'b00000}, {4'h4, 5'b10111},
    {4'h4, 5'b10010}, {4'h4, 5'b00000}, {4'h5, 5'b01011}, {4'h5, 5'b00000},
    {4'h5, 5'b10010}, {4'h5, 5'b00000}, {4'h6, 5'b11011}, {4'h6, 5'b10010},
    {4'h6, 5'b00000}, {4'h7, 5'b11111}, {4'h7, 5'b10100}, {4'h7, 5'b11100},
    {4'h7, 5'b01000}, {4'h8, 5'b10010}, {4'h8, 5'b00010}, {4'h8, 5'b01000},
    {4'h8, 5'b00000}, {4'h3, 5'b01000}, {4'h3, 5'b11010}, {4'h3, 5'b01010},
    {4'h3, 5'b00000}};

  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] scheme = DSS_SCH_EDGE_FWD_REV;
  logic [1:0] cfg_place = DSS_PLC_TERM;
  logic decel_ok = 1'b0;
  logic [15:0] interval = 16'h0000;
  logic [15:0] io_ref = 16'h0000;
  logic [15:0] ref_out;
  logic [15:0] pot_ref;
  logic [15:0] p;
  dss_contacts_t req;
  dss_contacts_t cont;
  dss_place_cmd_t kpd;
  dss_place_cmd_t fb;
  dss_cmd_t cmd;
  int n_errors = 0;
  int check_count = 0;
  int n;

  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;

  dss_contact_model dss_contact_model_inst (.clk_i(clk_i), .req_i(req),
    .cont_o(cont));
  dss_core #(.MS_CYC(MS), .POT_DIV(PD)) dss_core_inst (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .cont_i(cont), .scheme_i(scheme),
    .cfg_place_i(cfg_place), .decel_ok_i(decel_ok), .pot_ref_sel_i(1'b0),
    .reference_interp_interval_i(interval), .io_ref_i(io_ref),
    .jog_ref_i(16'h0123), .kpd_i(kpd), .fb_i(fb), .cmd_o(cmd),
    .ref_o(ref_out), .pot_ref_o(pot_ref));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask : cyc

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    req = '0;
    req.run_en = 1'b1;
    req.ext_flt_ok = 1'b1;
    req.first_contact_input = 1'b1;
    kpd = '0;
    fb = '0;
    // start contact held closed through reset must not start
    cyc(6);
    check(cmd, 32'h0);
    sys_rst_i = 1'b0;
    cyc(6);
    check(cmd.run, 1'b0);
    req.first_contact_input = 1'b0;
    cyc(5);
    req.first_contact_input = 1'b1;
    cyc(5);
    check(cmd.run, 1'b1);
    req.first_contact_input = 1'b0;
    cyc(5);
    $display("reset test done");
    foreach (ROWS[i])
    begin
      scheme = ROWS[i].sch;
      req.first_contact_input = ROWS[i].c1;
      req.second_contact_input = ROWS[i].c2;
      req.rev_sel = ROWS[i].rs;
      cyc(5);
      check(cmd.run, ROWS[i].run);
      if (ROWS[i].run)
        check(cmd.rev, ROWS[i].rev);
    end
    $display("scheme table done");
    // run enable drop in an edge scheme: coast, then rearm needed
    scheme = DSS_SCH_EDGE_RUN_DIRECTION;
    req.first_contact_input = 1'b1;
    cyc(5);
    req.run_en = 1'b0;
    cyc(5);
    check({cmd.coast, cmd.warn_run_dis, cmd.run}, 3'b110);
    req.run_en = 1'b1;
    cyc(5);
    check(cmd.run, 1'b0);
    req.first_contact_input = 1'b0;
    cyc(5);
    $display("run enable test done");
    // faults: latched, cleared by edge only
    req.ext_flt_close = 1'b1;
    cyc(5);
    check({cmd.flt, cmd.flt_code}, {1'b1, DSS_FLT_EXT});
    req.ext_flt_close = 1'b0;
    cyc(5);
    check(cmd.flt, 1'b1);
    req.flt_rst = 1'b1;
    n = 0;
    repeat (6)
    begin
      cyc(1);
      n += (cmd.flt_clr === 1'b1);
    end
    check(n, 1);
    req.ext_flt_ok = 1'b0;
    cyc(5);
    check({cmd.flt, cmd.flt_code}, {1'b1, DSS_FLT_EXT});
    req.ext_flt_ok = 1'b1;
    cyc(5);
    check(cmd.flt, 1'b1);
    req.flt_rst = 1'b0;
    cyc(5);
    req.flt_rst = 1'b1;
    cyc(5);
    check(cmd.flt, 1'b0);
    req.flt_rst = 1'b0;
    $display("fault test done");
    // level selects while stopped
    for (int i = 0; i < 8; i++)
    begin
      req.preset = i[2:0];
      req.ramp_sel = i[0];
      req.jog = i[1];
      req.ramp_hold = i[2];
      req.dc_brake_input = i[0];
      decel_ok = i[1];
      cyc(5);
      check(cmd.preset, i);
      check(cmd.ramp_set2, i[0]);
      check({cmd.jog, cmd.dc_brake}, {i[1], i[0]});
      check({cmd.hold_acc, cmd.hold_dec}, {i[2], i[2] & ~i[1]});
    end
    req.ramp_hold = 1'b0;
    req.jog = 1'b0;
    $display("select test done");
    // motor pot raise then lower while running, brake held off
    scheme = DSS_SCH_RUN_WITH_POT_RAISE;
    req.first_contact_input = 1'b1;
    req.second_contact_input = 1'b1;
    cyc(5);
    p = pot_ref;
    check({cmd.pot_up, cmd.pot_down}, 2'b10);
    cyc(40);
    check(pot_ref > p, 1'b1);
    check(cmd.dc_brake, 1'b0);
    req.second_contact_input = 1'b0;
    req.pot_down = 1'b1;
    cyc(4);
    p = pot_ref;
    check({cmd.pot_up, cmd.pot_down}, 2'b01);
    cyc(20);
    check(pot_ref < p, 1'b1);
    req.pot_down = 1'b0;
    req.first_contact_input = 1'b0;
    req.dc_brake_input = 1'b0;
    cyc(5);
    $display("pot test done");
    // forced places and their priority
    kpd = '{run: 1'b1, rev: 1'b1, ref_val: 16'h0000};
    req.frc_kpd = 1'b1;
    cyc(5);
    check({cmd.place, cmd.run, cmd.rev}, {DSS_PLC_KPD, 2'b11});
    req.frc_fb = 1'b1;
    cyc(5);
    check({cmd.place, cmd.run}, {DSS_PLC_FB, 1'b0});
    req.frc_term = 1'b1;
    cyc(5);
    check(cmd.place, DSS_PLC_TERM);
    req.frc_term = 1'b0;
    req.frc_fb = 1'b0;
    req.frc_kpd = 1'b0;
    kpd.run = 1'b0;
    cyc(5);
    check(cmd.place, cfg_place);
    $display("place test done");
    // reference ramps over the interval, steps with interval zero
    interval = 16'h0001;
    io_ref = 16'h0064;
    cyc(4);
    check(ref_out == 16'h0064, 1'b0);
    cyc(MS + 4);
    check(ref_out, 16'h0064);
    interval = 16'h0000;
    io_ref = 16'h0032;
    cyc(4);
    check(ref_out, 16'h0032);
    $display("reference test done");
    test_done();
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (3000) @(posedge clk_i);
    n_errors++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
